// ===== hdl/mlw_regs.svh
`ifndef MLW_REGS_SVH
`define MLW_REGS_SVH
// word addresses of the watchdog registers
`define MLW_ADDR_LIMIT   16'h1000
`define MLW_ADDR_MASK_LO 16'h1001
`define MLW_ADDR_MASK_HI 16'h1002
`define MLW_ADDR_TRIG    16'h1003
`define MLW_ADDR_MIN     16'h1004
`define MLW_ADDR_KSTOP   16'h1005
`define MLW_ADDR_STATE   16'h1006
`define MLW_ADDR_REARM   16'h1007
`define MLW_ADDR_SSTOP   16'h1008
// reset values
`define MLW_RST_LIMIT    16'h0064
`define MLW_RST_MASK     16'hFFFF
`define MLW_RST_MIN      16'hFFFF
`define MLW_RST_WORD     16'h0000
// key words and commands
`define MLW_KEY_FIRST    16'hAAAA
`define MLW_KEY_SECOND   16'h5555
`define MLW_SKEY_A       16'hAA55
`define MLW_SKEY_B       16'h55AA
`define MLW_REARM_CMD    16'h0001
// function code field
`define MLW_FC_LO_FIRST  8'h01
`define MLW_FC_HI_FIRST  8'h11
`define MLW_FC_HI_LAST   8'h20
// timebase
`define MLW_TICK_MS      100
`define MLW_CLK_MHZ      200
`define MLW_TICK_CYCLES  (`MLW_TICK_MS * 1000 * `MLW_CLK_MHZ)
`endif

// ===== hdl/mlw_pkg.sv
package mlw_pkg;
  typedef enum logic [1:0] {
    MLW_IDLE    = 2'h0,
    MLW_ACTIVE  = 2'h1,
    MLW_EXPIRED = 2'h2
  } mlw_state_type;
  typedef logic [15:0] mlw_word_type;
endpackage

// ===== hdl/mlw_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mlw_regs.svh"
module mlw_top #(
  parameter int unsigned TICK_CYCLES = `MLW_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  // register access, one word each
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [15:0]            reg_addr,
  input  wire mlw_pkg::mlw_word_type  reg_wdata,
  output var  mlw_pkg::mlw_word_type  reg_rdata,
  output var  logic                   reg_ack,
  // received function codes
  input  wire logic                   fc_valid,
  input  wire logic [7:0]             fc_code,
  // watchdog outputs
  output var  mlw_pkg::mlw_state_type wd_state,
  output var  logic                   wd_fault,
  output var  logic                   pd_write_en
);
  import mlw_pkg::*;

  mlw_state_type state_reg, state_next;
  mlw_word_type  limit_reg, limit_next;
  mlw_word_type  mask_lo_reg, mask_lo_next;
  mlw_word_type  mask_hi_reg, mask_hi_next;
  mlw_word_type  trig_reg, trig_next;
  mlw_word_type  min_reg, min_next;
  mlw_word_type  kstop_reg, kstop_next;
  mlw_word_type  rearm_reg, rearm_next;
  mlw_word_type  sstop_reg, sstop_next;
  mlw_word_type  elapsed_reg, elapsed_next;
  mlw_word_type  rdata_reg, rdata_next;
  logic [31:0]   pre_reg, pre_next;
  logic          armed_reg, armed_next;
  logic          fault_reg, fault_next;
  logic          pden_reg, pden_next;
  logic          ack_reg, ack_next;
  logic trig_ok;
  logic fc_ok;
  logic kstop_done;
  logic sstop_done;
  logic rearm_ok;
  logic tick;
  logic expire;
  logic retrig;

  // enabled code test, used for both masks
  function automatic logic fc_hit(input logic [7:0] code,
                                  input mlw_word_type lo,
                                  input mlw_word_type hi);
    logic [7:0] idx;
    idx = 8'h00;
    if (code >= `MLW_FC_LO_FIRST && code < `MLW_FC_HI_FIRST) begin
      idx = code - `MLW_FC_LO_FIRST;
      return lo[idx[3:0]];
    end
    if (code >= `MLW_FC_HI_FIRST && code <= `MLW_FC_HI_LAST) begin
      idx = code - `MLW_FC_HI_FIRST;
      return hi[idx[3:0]];
    end
    return 1'b0;
  endfunction

  function automatic logic wr_at(input logic [15:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  always_comb begin
    trig_ok = wr_at(`MLW_ADDR_TRIG) && (reg_wdata != trig_reg)
              && (limit_reg != 16'h0000)
              && ((state_reg != MLW_IDLE) || (reg_wdata != 16'h0000));
    fc_ok = fc_valid && (state_reg == MLW_ACTIVE)
            && fc_hit(fc_code, mask_lo_reg, mask_hi_reg);
    kstop_done = wr_at(`MLW_ADDR_KSTOP)
                 && (reg_wdata == `MLW_KEY_SECOND) && armed_reg;
    sstop_done = wr_at(`MLW_ADDR_SSTOP)
                 && ((reg_wdata == `MLW_SKEY_A)
                     || (reg_wdata == `MLW_SKEY_B));
    rearm_ok = wr_at(`MLW_ADDR_REARM)
               && (reg_wdata == `MLW_REARM_CMD)
               && (state_reg == MLW_EXPIRED);
    tick = (pre_reg == TICK_CYCLES[31:0] - 32'h1);
    expire = (state_reg == MLW_ACTIVE) && tick
             && ({16'h0000, elapsed_reg} + 32'h1 >= {16'h0000, limit_reg});
    retrig = trig_ok || fc_ok || rearm_ok;
  end

  always_comb begin
    state_next   = state_reg;
    limit_next   = limit_reg;
    mask_lo_next = mask_lo_reg;
    mask_hi_next = mask_hi_reg;
    trig_next    = trig_reg;
    min_next     = min_reg;
    kstop_next   = kstop_reg;
    rearm_next   = rearm_reg;
    sstop_next   = sstop_reg;
    elapsed_next = elapsed_reg;
    pre_next     = pre_reg;
    armed_next   = armed_reg;
    fault_next   = fault_reg;
    pden_next    = pden_reg;
    // config is frozen while running
    if (state_reg != MLW_ACTIVE) begin
      if (wr_at(`MLW_ADDR_LIMIT))
        limit_next = reg_wdata;
      if (wr_at(`MLW_ADDR_MASK_LO))
        mask_lo_next = reg_wdata;
      if (wr_at(`MLW_ADDR_MASK_HI))
        mask_hi_next = reg_wdata;
    end
    if (wr_at(`MLW_ADDR_TRIG))
      trig_next = reg_wdata;
    if (wr_at(`MLW_ADDR_REARM))
      rearm_next = reg_wdata;
    if (wr_at(`MLW_ADDR_SSTOP))
      sstop_next = reg_wdata;
    // any other word breaks the sequence
    if (wr_at(`MLW_ADDR_KSTOP)) begin
      kstop_next = reg_wdata;
      armed_next = (reg_wdata == `MLW_KEY_FIRST);
    end
    if (state_reg == MLW_ACTIVE) begin
      pre_next = tick ? 32'h0 : pre_reg + 32'h1;
      if (tick)
        elapsed_next = elapsed_reg + 16'h0001;
    end
    if (kstop_done || sstop_done) begin
      state_next   = MLW_IDLE;
      fault_next   = 1'b0;
      pden_next    = 1'b1;
      elapsed_next = 16'h0000;
      pre_next     = 32'h0;
    end else if (retrig) begin
      if (state_reg == MLW_ACTIVE && elapsed_reg < min_reg)
        min_next = elapsed_reg;
      state_next   = MLW_ACTIVE;
      fault_next   = 1'b0;
      pden_next    = 1'b1;
      elapsed_next = 16'h0000;
      pre_next     = 32'h0;
    end else if (expire) begin
      state_next = MLW_EXPIRED;
      fault_next = 1'b1;
      pden_next  = 1'b0;
      pre_next   = 32'h0;
    end
  end

  // read mux, one word per access
  always_comb begin
    ack_next   = reg_rd || reg_wr;
    rdata_next = rdata_reg;
    if (reg_rd) begin
      unique case (reg_addr)
        `MLW_ADDR_LIMIT:   rdata_next = limit_reg;
        `MLW_ADDR_MASK_LO: rdata_next = mask_lo_reg;
        `MLW_ADDR_MASK_HI: rdata_next = mask_hi_reg;
        `MLW_ADDR_TRIG:    rdata_next = trig_reg;
        `MLW_ADDR_MIN:     rdata_next = min_reg;
        `MLW_ADDR_KSTOP:   rdata_next = kstop_reg;
        `MLW_ADDR_STATE:   rdata_next = {14'h0000, state_reg};
        `MLW_ADDR_REARM:   rdata_next = rearm_reg;
        `MLW_ADDR_SSTOP:   rdata_next = sstop_reg;
        default:           rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg   <= MLW_IDLE;
      limit_reg   <= `MLW_RST_LIMIT;
      mask_lo_reg <= `MLW_RST_MASK;
      mask_hi_reg <= `MLW_RST_MASK;
      trig_reg    <= `MLW_RST_WORD;
      min_reg     <= `MLW_RST_MIN;
      kstop_reg   <= `MLW_RST_WORD;
      rearm_reg   <= `MLW_RST_WORD;
      sstop_reg   <= `MLW_RST_WORD;
      elapsed_reg <= 16'h0000;
      pre_reg     <= 32'h0;
      armed_reg   <= 1'b0;
      fault_reg   <= 1'b0;
      pden_reg    <= 1'b1;
      rdata_reg   <= 16'h0000;
      ack_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      limit_reg   <= limit_next;
      mask_lo_reg <= mask_lo_next;
      mask_hi_reg <= mask_hi_next;
      trig_reg    <= trig_next;
      min_reg     <= min_next;
      kstop_reg   <= kstop_next;
      rearm_reg   <= rearm_next;
      sstop_reg   <= sstop_next;
      elapsed_reg <= elapsed_next;
      pre_reg     <= pre_next;
      armed_reg   <= armed_next;
      fault_reg   <= fault_next;
      pden_reg    <= pden_next;
      rdata_reg   <= rdata_next;
      ack_reg     <= ack_next;
    end
  end

  assign reg_rdata   = rdata_reg;
  assign reg_ack     = ack_reg;
  assign wd_state    = state_reg;
  assign wd_fault    = fault_reg;
  assign pd_write_en = pden_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_mask_hi_lock;
    state_reg == MLW_ACTIVE && wr_at(`MLW_ADDR_MASK_HI)
      |=> $stable(mask_hi_reg);
  endproperty
  a_mask_hi_lock: assert property (p_mask_hi_lock)
    else $error("upper mask changed while running");
  property p_mask_hi_rst;
    $rose(nrst) |-> mask_hi_reg == 16'hFFFF;
  endproperty
  a_mask_hi_rst: assert property (p_mask_hi_rst)
    else $error("upper mask not all ones after reset");
  property p_same_word;
    state_reg == MLW_IDLE && wr_at(`MLW_ADDR_TRIG)
      && reg_wdata == trig_reg |=> state_reg == MLW_IDLE;
  endproperty
  a_same_word: assert property (p_same_word)
    else $error("repeated trigger word started watchdog");
  property p_start;
    state_reg == MLW_IDLE && limit_reg != 16'h0000
      && wr_at(`MLW_ADDR_TRIG) && reg_wdata != 16'h0000
      && reg_wdata != trig_reg |=> state_reg == MLW_ACTIVE;
  endproperty
  a_start: assert property (p_start)
    else $error("nonzero trigger did not start watchdog");
  property p_trig_clear;
    state_reg == MLW_EXPIRED && trig_ok
      |=> !fault_reg && pden_reg && state_reg == MLW_ACTIVE;
  endproperty
  a_trig_clear: assert property (p_trig_clear)
    else $error("trigger did not clear fault");
  property p_min_down;
    ##1 min_reg <= $past(min_reg);
  endproperty
  a_min_down: assert property (p_min_down)
    else $error("minimum interval grew");
  property p_keyed;
    armed_reg && wr_at(`MLW_ADDR_KSTOP) && reg_wdata == `MLW_KEY_SECOND
      |=> state_reg == MLW_IDLE && !fault_reg && pden_reg;
  endproperty
  a_keyed: assert property (p_keyed)
    else $error("key sequence did not stop watchdog");
  property p_lone_key;
    !armed_reg && state_reg == MLW_ACTIVE && wr_at(`MLW_ADDR_KSTOP)
      |=> state_reg != MLW_IDLE;
  endproperty
  a_lone_key: assert property (p_lone_key)
    else $error("second key alone stopped watchdog");
  property p_status;
    reg_rd && reg_addr == `MLW_ADDR_STATE
      |=> reg_ack && reg_rdata == {14'h0000, $past(state_reg)};
  endproperty
  a_status: assert property (p_status)
    else $error("status read wrong");
  property p_rearm;
    state_reg == MLW_EXPIRED && wr_at(`MLW_ADDR_REARM)
      && reg_wdata == 16'h0001 |=> state_reg == MLW_ACTIVE;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("rearm did not restart");
  property p_no_rearm;
    state_reg == MLW_IDLE && wr_at(`MLW_ADDR_REARM)
      |=> state_reg == MLW_IDLE;
  endproperty
  a_no_rearm: assert property (p_no_rearm)
    else $error("stopped watchdog was rearmed");
  property p_zero_limit;
    state_reg == MLW_IDLE && limit_reg == 16'h0000
      |=> state_reg == MLW_IDLE;
  endproperty
  a_zero_limit: assert property (p_zero_limit)
    else $error("started with zero limit");
  property p_single;
    sstop_done |=> state_reg == MLW_IDLE && !fault_reg;
  endproperty
  a_single: assert property (p_single)
    else $error("single key did not stop");
  property p_expire;
    expire && !kstop_done && !sstop_done && !retrig
      |=> state_reg == MLW_EXPIRED && fault_reg && !pden_reg;
  endproperty
  a_expire: assert property (p_expire)
    else $error("timeout not flagged");
endmodule // mlw_top
`default_nettype wire

// ===== bench/mlw_client.sv
`timescale 1ns/1ps
`default_nettype none
`include "mlw_regs.svh"
module mlw_client (
  // clock
  input  wire logic                  sys_clk,
  // register access
  output var  logic                  reg_wr,
  output var  logic                  reg_rd,
  output var  logic [15:0]           reg_addr,
  output var  mlw_pkg::mlw_word_type reg_wdata,
  input  wire mlw_pkg::mlw_word_type reg_rdata,
  input  wire logic                  reg_ack,
  // received function codes
  output var  logic                  fc_valid,
  output var  logic [7:0]            fc_code
);
  import mlw_pkg::*;
  mlw_word_type trig_reg = 16'h0000;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    fc_valid = 1'b0;
    fc_code = 8'h00;
  end
  task automatic xfer(input logic wr, input logic [15:0] a,
                      input mlw_word_type d, output mlw_word_type q,
                      output logic ack);
    @(posedge sys_clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // released lines flip so stale data never looks valid
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata;
    ack = reg_ack;
  endtask
  // word always changes, never zero first
  task automatic next_trigger(output logic ack);
    mlw_word_type q;
    trig_reg = trig_reg + 16'h0001;
    xfer(1'b1, `MLW_ADDR_TRIG, trig_reg, q, ack);
  endtask
  task automatic key_stop(output logic ack);
    mlw_word_type q;
    xfer(1'b1, `MLW_ADDR_KSTOP, `MLW_KEY_FIRST, q, ack);
    xfer(1'b1, `MLW_ADDR_KSTOP, `MLW_KEY_SECOND, q, ack);
  endtask
  // one function code, valid for a single cycle
  task automatic send_code(input logic [7:0] c);
    @(posedge sys_clk);
    fc_valid <= 1'b1;
    fc_code <= c;
    @(posedge sys_clk);
    fc_valid <= 1'b0;
    fc_code <= ~c;
  endtask
endmodule // mlw_client
`default_nettype wire

// ===== bench/modbus_link_watchdog_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mlw_regs.svh"
module modbus_link_watchdog_control_bench;
  import mlw_pkg::*;
  localparam int TICK = 4;
  localparam int LIM = 3;
  localparam logic [3:0] S_IDLE = 4'h1;
  localparam logic [3:0] S_ACT = 4'h5;
  localparam logic [3:0] S_EXP = 4'hA;
  logic sys_clk, nrst, reg_wr, reg_rd, reg_ack, fc_valid;
  logic wd_fault, pd_write_en;
  logic [15:0] reg_addr;
  logic [7:0] fc_code;
  mlw_word_type reg_wdata, reg_rdata, q;
  mlw_state_type wd_state;
  logic ack;
  int num_errors = 0;
  int cmp_count = 0;
  mlw_top #(.TICK_CYCLES(TICK)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .fc_valid(fc_valid), .fc_code(fc_code), .wd_state(wd_state),
    .wd_fault(wd_fault), .pd_write_en(pd_write_en));
  mlw_client cli (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .fc_valid(fc_valid), .fc_code(fc_code));
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input mlw_word_type d);
    cli.xfer(1'b1, a, d, q, ack);
    chk("write ack", {15'h0000, ack}, 16'h0001);
  endtask
  task automatic rd(input string nm, input logic [15:0] a,
                    input mlw_word_type e);
    cli.xfer(1'b0, a, 16'h0000, q, ack);
    chk(nm, q, e);
  endtask
  task automatic st(input logic [3:0] e);
    chk("outputs", {12'h000, wd_state, wd_fault, pd_write_en}, {12'h000, e});
  endtask
  task automatic go;
    cli.next_trigger(ack);
  endtask
  task automatic wait_exp;
    int n;
    n = 0;
    while (wd_state !== MLW_EXPIRED && n < LIM * TICK + 8) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    st(S_EXP);
  endtask
  task automatic t_reset;
    mlw_word_type rst_val [10];
    rst_val = '{16'h0064, 16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFF,
                16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    st(S_IDLE);
    for (int i = 0; i < 10; i++) begin
      rd("reset word", `MLW_ADDR_LIMIT + 16'(i), rst_val[i]);
    end
    $display("test reset done");
  endtask
  task automatic t_start;
    wr(`MLW_ADDR_LIMIT, 16'h0000);
    go;
    st(S_IDLE);
    wr(`MLW_ADDR_TRIG, 16'h0000);
    wr(`MLW_ADDR_LIMIT, 16'(LIM));
    st(S_IDLE);
    go;
    st(S_ACT);
    repeat ((LIM - 1) * TICK - 2) @(posedge sys_clk);
    #1;
    st(S_ACT);
    wait_exp;
    wr(`MLW_ADDR_TRIG, cli.trig_reg);
    st(S_EXP);
    go;
    st(S_ACT);
    // one tick before the next trigger
    repeat (TICK) @(posedge sys_clk);
    go;
    rd("min interval", `MLW_ADDR_MIN, 16'h0001);
    cli.key_stop(ack);
    $display("test start done");
  endtask
  task automatic t_masks;
    logic [7:0] codes [4];
    logic [3:0] exps [4];
    codes = '{8'h05, 8'h11, 8'h06, 8'h12};
    exps = '{S_ACT, S_ACT, S_EXP, S_EXP};
    wr(`MLW_ADDR_MASK_LO, 16'h0010);
    wr(`MLW_ADDR_MASK_HI, 16'h0001);
    go;
    wr(`MLW_ADDR_MASK_HI, 16'h0000);
    rd("upper mask", `MLW_ADDR_MASK_HI, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      go;
      repeat (8) begin
        cli.send_code(codes[i]);
        repeat (TICK) @(posedge sys_clk);
      end
      #1;
      st(exps[i]);
    end
    cli.key_stop(ack);
    wr(`MLW_ADDR_MASK_LO, 16'hFFFF);
    wr(`MLW_ADDR_MASK_HI, 16'hFFFF);
    rd("upper mask", `MLW_ADDR_MASK_HI, 16'hFFFF);
    $display("test masks done");
  endtask
  task automatic t_stop;
    logic [15:0] keys [2];
    keys = '{`MLW_SKEY_A, `MLW_SKEY_B};
    go;
    wr(`MLW_ADDR_KSTOP, `MLW_KEY_SECOND);
    wr(`MLW_ADDR_KSTOP, `MLW_KEY_FIRST);
    wr(`MLW_ADDR_KSTOP, 16'h1234);
    wr(`MLW_ADDR_KSTOP, `MLW_KEY_SECOND);
    st(S_ACT);
    wait_exp;
    cli.key_stop(ack);
    st(S_IDLE);
    for (int i = 0; i < 2; i++) begin
      go;
      wait_exp;
      wr(`MLW_ADDR_SSTOP, keys[i]);
      st(S_IDLE);
    end
    $display("test stop done");
  endtask
  task automatic t_rearm;
    go;
    wait_exp;
    rd("state word", `MLW_ADDR_STATE, 16'h0002);
    wr(`MLW_ADDR_REARM, 16'h0002);
    st(S_EXP);
    wr(`MLW_ADDR_REARM, `MLW_REARM_CMD);
    st(S_ACT);
    rd("state word", `MLW_ADDR_STATE, 16'h0001);
    // slower retrigger must not raise the minimum
    repeat (2 * TICK) @(posedge sys_clk);
    go;
    wr(`MLW_ADDR_MIN, 16'h1234);
    rd("min interval", `MLW_ADDR_MIN, 16'h0000);
    chk("min small", {15'h0000, q <= 16'h0003}, 16'h0001);
    cli.key_stop(ack);
    wr(`MLW_ADDR_TRIG, cli.trig_reg);
    st(S_IDLE);
    wr(`MLW_ADDR_REARM, `MLW_REARM_CMD);
    st(S_IDLE);
    wr(`MLW_ADDR_STATE, 16'h0002);
    rd("state word", `MLW_ADDR_STATE, 16'h0000);
    $display("test rearm done");
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // whole run needs a few hundred cycles
  initial begin
    #100000;
    num_errors++;
    end_of_test;
  end
  initial begin
    nrst = 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    t_reset;
    t_start;
    t_masks;
    t_stop;
    t_rearm;
    end_of_test;
  end
endmodule // modbus_link_watchdog_control_bench
`default_nettype wire
